// [sadc_params.svh]
`ifndef SADC_PARAMS_SVH
`define SADC_PARAMS_SVH

// Register word indices; the byte address is four times the index.
`define SADC_IDX_NEG 8'hBA
`define SADC_IDX_POS 8'hBB
`define SADC_IDX_CFG 8'hBC
`define SADC_IDX_RESL 8'hBD
`define SADC_IDX_RESH 8'hBE
`define SADC_IDX_IEN 8'hC0
`define SADC_IDX_CTRL 8'hE8

// Reset values.
`define SADC_POS_RST 5'h00
`define SADC_NEG_RST 5'h00
`define SADC_CFG_SC_RST 5'h00

// Control register bit positions.
`define SADC_CTRL_EN 7
`define SADC_CTRL_TM 6
`define SADC_CTRL_DONE 5
`define SADC_CTRL_BUSY 4
`define SADC_CTRL_CM_LO 0
`define SADC_CTRL_CM_HI 2

// Configuration register bit positions.
`define SADC_CFG_SC_LO 3
`define SADC_CFG_SC_HI 7
`define SADC_CFG_LJ 2

// Multiplexer codes.
`define SADC_POS_LAST_PIN 5'h14
`define SADC_CODE_TEMP 5'h1E
`define SADC_CODE_VDD 5'h1F
`define SADC_CODE_VREF 5'h1E
`define SADC_CODE_GND 5'h1F

// Timing in conversion-clock periods.
`define SADC_TRACK_CLKS 4'h3

// Bus answers.
`define SADC_RESP_OKAY 2'h0
`define SADC_RESP_SLVERR 2'h2

`endif

// [sadc_pkg.sv]
package sadc_pkg;

  typedef enum logic [2:0] {
    SADC_SRC_SW,
    SADC_SRC_T0,
    SADC_SRC_T2,
    SADC_SRC_T1,
    SADC_SRC_EXT,
    SADC_SRC_T3
  } sadc_src_t;

  typedef enum logic [1:0] {
    SADC_IDLE,
    SADC_TRACK,
    SADC_CONV
  } sadc_state_t;

  // Timer overflow strobes and timer width modes, all on sys_clk.
  typedef struct packed {
    logic t0_ovf;
    logic t1_ovf;
    logic t2_lo_ovf;
    logic t2_hi_ovf;
    logic t2_16bit;
    logic t3_lo_ovf;
    logic t3_hi_ovf;
    logic t3_16bit;
  } sadc_tmr_t;

  // Controls toward the analog converter core.
  typedef struct packed {
    logic track;
    logic convert;
    logic sar_tick;
    logic single_ended;
    logic sel_reserved;
    logic [4:0] pos_sel;
    logic [4:0] neg_sel;
  } sadc_core_t;

endpackage

// [sadc_sequencer.sv]
// Operation
// - Negative input ground means single-ended; any other negative input means differential.
// - Single-ended results are 10-bit unsigned; full scale 0x03FF right, 0xFFC0 left.
// - Justify bit picks right or left; single-ended unused bits read zero.
// - Differential right-justified sign-extends the high byte; left-justified clears low bits.
// - Differential results are 10-bit two's complement, largest 0x01FF or 0x7FC0.
// - Conversion clock is system clock divided by divider field plus one.
// - Start-source field picks software, timer 0, 2, 1, external pin or timer 3.
// - In-progress bit reads one throughout a conversion and clears at its end.
// - When in-progress falls, done flag sets and enabled interrupt rises.
// - Result bytes are valid whenever done is set; software should poll done.
// - Timers 2 and 3 trigger on low overflow in 8-bit, high in 16-bit.
// - Normal track mode tracks continuously while enabled, except during conversion.
// - Low-power track mode tracks three conversion clocks after each start.
// - Low-power mode with external pin tracks while low, converts on rising edge.
// - Tracking may stop while the device is in standby or sleep.
// - Positive codes 0 to 0x14 pick port pins; 0x15 to 0x1D are reserved.
// - Positive code 0x1E routes the temperature sensor, 0x1F routes supply.
// - Negative input may be any port pin, the reference or ground.
// - Start-source code 101 means timer 3; codes 11x are reserved.
// - Writing one to in-progress starts only with source 000; zero does nothing.
// - With the enable bit clear there is no tracking and no conversion.
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "sadc_params.svh"

module sadc_sequencer #(
  parameter int ADDR_W = 12,
  parameter int CONV_CLKS = 11
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire sadc_pkg::sadc_tmr_t tmr,
  input wire logic external_start_pin,
  input wire logic standby,
  input wire logic [9:0] core_code,
  output sadc_pkg::sadc_core_t core_q,
  output logic irq_q
);

  if (ADDR_W < 11 || CONV_CLKS < 1 || CONV_CLKS > 15) begin : g_chk
    $error("sadc_sequencer: ADDR_W must be at least 11 and CONV_CLKS within 1 to 15");
  end

  localparam logic [3:0] CONV_LAST = 4'(CONV_CLKS - 1);
  localparam logic [3:0] TRACK_LAST = `SADC_TRACK_CLKS - 4'h1;

  // Word index with an out-of-range flag on top.
  function automatic logic [8:0] dec(input logic [ADDR_W-1:0] a);
    dec = {(a >> 10) != '0, a[9:2]};
  endfunction

  // Places a raw code in the 16-bit result word.
  function automatic logic [15:0] fmt(input logic [9:0] c, input logic lj, input logic se);
    if (lj) begin
      fmt = {c, 6'h00};
    end else if (se) begin
      fmt = {6'h00, c};
    end else begin
      fmt = {{6{c[9]}}, c};
    end
  endfunction

  logic aw_got_q, w_got_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wstrb_q;
  logic [4:0] pos_q, neg_q, sc_q;
  logic lj_q, en_q, tm_q, done_q, ien_q;
  logic [2:0] cm_q;
  logic [15:0] result_q;
  logic [4:0] div_q;
  logic [3:0] seq_q;
  logic ext_s1_q, ext_s2_q, ext_s3_q;
  sadc_pkg::sadc_state_t state_q;
  logic wr_do, wr_ok, tick, trig, ext_rise, busy, conv_end, start_ok, sw_go;
  logic [8:0] widx, ridx;
  logic [7:0] rbyte;

  // Write side: address and data are held independently, then applied together.
  assign wr_do = aw_got_q && w_got_q && !s_axi_bvalid;
  assign widx = dec(awaddr_q);
  assign wr_ok = wstrb_q && !widx[8];

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SADC_RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= 8'h00;
      wstrb_q <= 1'b0;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        s_axi_awready <= 1'b0;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        s_axi_wready <= 1'b0;
        wdata_q <= s_axi_wdata[7:0];
        wstrb_q <= s_axi_wstrb[0];
      end
      if (wr_do) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= widx[8] ? `SADC_RESP_SLVERR : `SADC_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read side: one cycle from address to data, held until taken.
  assign ridx = dec(s_axi_araddr);

  always_comb begin
    rbyte = 8'h00;
    unique case (ridx)
      {1'b0, `SADC_IDX_NEG}: rbyte = {3'h0, neg_q};
      {1'b0, `SADC_IDX_POS}: rbyte = {3'h0, pos_q};
      {1'b0, `SADC_IDX_CFG}: rbyte = {sc_q, lj_q, 2'h0};
      {1'b0, `SADC_IDX_RESL}: rbyte = result_q[7:0];
      {1'b0, `SADC_IDX_RESH}: rbyte = result_q[15:8];
      {1'b0, `SADC_IDX_IEN}: rbyte = {7'h00, ien_q};
      {1'b0, `SADC_IDX_CTRL}: rbyte = {en_q, tm_q, done_q, busy, 1'b0, cm_q};
      default: rbyte = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `SADC_RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rbyte};
        s_axi_rresp <= ridx[8] ? `SADC_RESP_SLVERR : `SADC_RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Configuration registers written by software.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pos_q <= `SADC_POS_RST;
      neg_q <= `SADC_NEG_RST;
      sc_q <= `SADC_CFG_SC_RST;
      lj_q <= 1'b0;
      ien_q <= 1'b0;
      en_q <= 1'b0;
      tm_q <= 1'b0;
      cm_q <= 3'h0;
    end else if (clk_en && wr_do && wr_ok) begin
      unique case (widx[7:0])
        `SADC_IDX_POS: pos_q <= wdata_q[4:0];
        `SADC_IDX_NEG: neg_q <= wdata_q[4:0];
        `SADC_IDX_CFG: begin
          sc_q <= wdata_q[`SADC_CFG_SC_HI:`SADC_CFG_SC_LO];
          lj_q <= wdata_q[`SADC_CFG_LJ];
        end
        `SADC_IDX_IEN: ien_q <= wdata_q[0];
        `SADC_IDX_CTRL: begin
          en_q <= wdata_q[`SADC_CTRL_EN];
          tm_q <= wdata_q[`SADC_CTRL_TM];
          cm_q <= wdata_q[`SADC_CTRL_CM_HI:`SADC_CTRL_CM_LO];
        end
        default: ;
      endcase
    end
  end

  // External start pin synchroniser; the third stage only serves the edge detector.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else if (clk_en) begin
      ext_s1_q <= external_start_pin;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  assign ext_rise = ext_s2_q && !ext_s3_q;

  // A software start is judged by the source field written with it, so one write can pick 000 and start.
  assign sw_go = wr_do && wr_ok && widx[7:0] == `SADC_IDX_CTRL && wdata_q[`SADC_CTRL_BUSY]
                 && wdata_q[`SADC_CTRL_CM_HI:`SADC_CTRL_CM_LO] == sadc_pkg::SADC_SRC_SW;

  // Start source selection; reserved codes never start anything.
  always_comb begin
    trig = 1'b0;
    unique case (cm_q)
      sadc_pkg::SADC_SRC_SW: trig = 1'b0;  // Software starts arrive through sw_go.
      sadc_pkg::SADC_SRC_T0: trig = tmr.t0_ovf;
      sadc_pkg::SADC_SRC_T2: trig = tmr.t2_16bit ? tmr.t2_hi_ovf : tmr.t2_lo_ovf;
      sadc_pkg::SADC_SRC_T1: trig = tmr.t1_ovf;
      sadc_pkg::SADC_SRC_EXT: trig = ext_rise;
      sadc_pkg::SADC_SRC_T3: trig = tmr.t3_16bit ? tmr.t3_hi_ovf : tmr.t3_lo_ovf;
      default: trig = 1'b0;
    endcase
  end

  // Conversion clock divider, restarted at each start so periods align.
  assign tick = div_q == sc_q;
  assign busy = state_q != sadc_pkg::SADC_IDLE;
  assign start_ok = en_q && !standby && (trig || sw_go);
  assign conv_end = state_q == sadc_pkg::SADC_CONV && tick && seq_q == CONV_LAST;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_q <= 5'h00;
    end else if (clk_en) begin
      if (!busy || tick) begin
        div_q <= 5'h00;
      end else begin
        div_q <= div_q + 5'h01;
      end
    end
  end

  // Track and convert sequencer.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= sadc_pkg::SADC_IDLE;
      seq_q <= 4'h0;
    end else if (clk_en) begin
      if (!en_q) begin
        state_q <= sadc_pkg::SADC_IDLE;
        seq_q <= 4'h0;
      end else begin
        unique case (state_q)
          sadc_pkg::SADC_IDLE: begin
            seq_q <= 4'h0;
            if (start_ok) begin
              if (tm_q && cm_q != sadc_pkg::SADC_SRC_EXT) begin
                state_q <= sadc_pkg::SADC_TRACK;
              end else begin
                state_q <= sadc_pkg::SADC_CONV;
              end
            end
          end
          sadc_pkg::SADC_TRACK: begin
            if (tick) begin
              if (seq_q == TRACK_LAST) begin
                state_q <= sadc_pkg::SADC_CONV;
                seq_q <= 4'h0;
              end else begin
                seq_q <= seq_q + 4'h1;
              end
            end
          end
          sadc_pkg::SADC_CONV: begin
            if (tick) begin
              if (seq_q == CONV_LAST) begin
                state_q <= sadc_pkg::SADC_IDLE;
                seq_q <= 4'h0;
              end else begin
                seq_q <= seq_q + 4'h1;
              end
            end
          end
          default: state_q <= sadc_pkg::SADC_IDLE;
        endcase
      end
    end
  end

  // Result capture and completion flag; a completion beats a clearing write.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      result_q <= 16'h0000;
      done_q <= 1'b0;
    end else if (clk_en) begin
      if (conv_end) begin
        result_q <= fmt(core_code, lj_q, neg_q == `SADC_CODE_GND);
        done_q <= 1'b1;
      end else if (wr_do && wr_ok && widx[7:0] == `SADC_IDX_CTRL) begin
        done_q <= wdata_q[`SADC_CTRL_DONE];
      end
    end
  end

  // Core controls and interrupt, all registered.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      core_q <= '0;
      irq_q <= 1'b0;
    end else if (clk_en) begin
      core_q.track <= en_q && !standby && (state_q == sadc_pkg::SADC_TRACK ||
                      (state_q == sadc_pkg::SADC_IDLE && (!tm_q ||
                      (cm_q == sadc_pkg::SADC_SRC_EXT && !ext_s2_q))));
      core_q.convert <= state_q == sadc_pkg::SADC_CONV;
      core_q.sar_tick <= state_q == sadc_pkg::SADC_CONV && tick;
      core_q.single_ended <= neg_q == `SADC_CODE_GND;
      core_q.sel_reserved <= pos_q > `SADC_POS_LAST_PIN && pos_q < `SADC_CODE_TEMP ||
                             neg_q > `SADC_POS_LAST_PIN && neg_q < `SADC_CODE_VREF;
      core_q.pos_sel <= pos_q;
      core_q.neg_sel <= neg_q;
      irq_q <= done_q && ien_q;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_conv_last;
    clk_en && conv_end;
  endsequence

  sequence s_done_set;
    done_q && !busy;
  endsequence

  a_done_on_end: assert property (s_conv_last |=> s_done_set)
    else $error("done flag not set at end of conversion");
  a_irq_follow: assert property (clk_en && done_q && ien_q |=> irq_q)
    else $error("interrupt not raised for done flag");
  a_se_mode: assert property (clk_en |=> core_q.single_ended == ($past(neg_q) == `SADC_CODE_GND))
    else $error("single-ended mode does not follow ground selection");
  a_right_se: assert property (s_conv_last and !lj_q && neg_q == `SADC_CODE_GND |=> result_q[15:10] == 6'h00)
    else $error("single-ended right result has nonzero upper bits");
  a_right_diff: assert property (s_conv_last and !lj_q && neg_q != `SADC_CODE_GND
                                 |=> result_q[15:10] == {6{result_q[9]}})
    else $error("differential right result not sign-extended");
  a_left_low: assert property (s_conv_last and lj_q |=> result_q[5:0] == 6'h00
                               && result_q[15:6] == $past(core_code))
    else $error("left-justified result misplaced");
  a_div_range: assert property (busy && !tick && clk_en |=> div_q == $past(div_q) + 5'h01)
    else $error("conversion clock divider skipped a count");
  a_lp_track: assert property (clk_en && en_q && state_q == sadc_pkg::SADC_TRACK && tick
                               && seq_q == TRACK_LAST |=> state_q == sadc_pkg::SADC_CONV)
    else $error("low-power tracking did not end after three conversion clocks");
  a_sw_refuse: assert property (clk_en && state_q == sadc_pkg::SADC_IDLE && cm_q != 3'h0 && !trig && !sw_go
                                |=> state_q == sadc_pkg::SADC_IDLE)
    else $error("conversion started without a trigger");
  a_disabled: assert property (clk_en && !en_q |=> !busy ##1 !core_q.convert)
    else $error("converter active while disabled");
  a_normal_track: assert property (clk_en && en_q && !tm_q && !standby && !busy |=> core_q.track)
    else $error("normal mode not tracking while idle");

endmodule

// [sadc_far_model.sv]
`timescale 1ns/1ns
// Far side of the sequencer: timers, the start pin and a core that returns a preset code.
module sadc_far_model (
  input wire logic sys_clk,
  input wire logic [7:0] tmr_req,
  input wire logic pin_req,
  input wire logic [9:0] code_req,
  input wire sadc_pkg::sadc_core_t core_q,
  output sadc_pkg::sadc_tmr_t tmr = 8'h00,
  output logic external_start_pin = 1'b0,
  output logic [9:0] core_code
);
  // Overflows last one cycle, as a free-running timer gives them; levels follow the request.
  always @(posedge sys_clk) begin
    tmr <= tmr_req;
    external_start_pin <= pin_req;
  end
  // The core shows its code only while converting, so a late sample sees the inverse.
  assign core_code = core_q.convert ? code_req : ~code_req;
endmodule

// [tb_top.sv]
`timescale 1ns/1ns
`include "sadc_params.svh"
module tb_top;
  localparam int CC = 2;
  localparam logic [11:0] A_NEG = {2'b00, `SADC_IDX_NEG, 2'b00};
  localparam logic [11:0] A_POS = {2'b00, `SADC_IDX_POS, 2'b00};
  localparam logic [11:0] A_CFG = {2'b00, `SADC_IDX_CFG, 2'b00};
  localparam logic [11:0] A_RESL = {2'b00, `SADC_IDX_RESL, 2'b00};
  localparam logic [11:0] A_RESH = {2'b00, `SADC_IDX_RESH, 2'b00};
  localparam logic [11:0] A_IEN = {2'b00, `SADC_IDX_IEN, 2'b00};
  localparam logic [11:0] A_CTRL = {2'b00, `SADC_IDX_CTRL, 2'b00};
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic [7:0] tmr_req = 8'h00;
  logic pin_req = 1'b0, standby = 1'b0;
  logic [9:0] code_req = 10'h000;
  logic awready, wready, bvalid, arready, rvalid, irq_q, ext_pin;
  logic [1:0] bresp, rresp, last_resp;
  logic [31:0] rdata, rd;
  logic [9:0] core_code;
  sadc_pkg::sadc_tmr_t tmr;
  sadc_pkg::sadc_core_t core_q;
  int failures = 0, n_checks = 0, cyc = 0, last_tick = 0, gap = 0, n_tick = 0, n_track = 0;
  // Result cases: negative select, left-justify, raw code, expected result word.
  logic [31:0] rows [9] = '{{5'h1F, 1'b0, 10'h3FF, 16'h03FF}, {5'h1F, 1'b1, 10'h3FF, 16'hFFC0},
    {5'h1F, 1'b0, 10'h200, 16'h0200}, {5'h1F, 1'b1, 10'h200, 16'h8000}, {5'h1E, 1'b0, 10'h300, 16'hFF00},
    {5'h1E, 1'b1, 10'h300, 16'hC000}, {5'h1E, 1'b0, 10'h1FF, 16'h01FF}, {5'h1E, 1'b1, 10'h1FF, 16'h7FC0},
    {5'h03, 1'b0, 10'h000, 16'h0000}};
  // Trigger cases: control byte, timer strobes, pin, standby, whether a conversion completes.
  logic [18:0] trg [17] = '{{8'h81, 8'h80, 3'b001}, {8'h82, 8'h20, 3'b001}, {8'h82, 8'h18, 3'b001},
    {8'h82, 8'h28, 3'b000}, {8'h83, 8'h40, 3'b001}, {8'h84, 8'h00, 3'b101}, {8'h85, 8'h04, 3'b001},
    {8'h85, 8'h03, 3'b001}, {8'h85, 8'h05, 3'b000}, {8'h86, 8'hFF, 3'b100}, {8'h87, 8'hFF, 3'b100},
    {8'h80, 8'hFF, 3'b100}, {8'h91, 8'h00, 3'b000}, {8'h80, 8'h00, 3'b000}, {8'h11, 8'h80, 3'b000},
    {8'h81, 8'h80, 3'b010}, {8'h90, 8'h00, 3'b001}};

  // The system clock at 25 MHz.
  always #20 sys_clk = ~sys_clk;

  sadc_sequencer #(.ADDR_W(12), .CONV_CLKS(CC)) i_sadc_sequencer (.sys_clk(sys_clk), .rst_b(rst_b),
    .clk_en(1'b1), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tmr(tmr), .external_start_pin(ext_pin),
    .standby(standby), .core_code(core_code), .core_q(core_q), .irq_q(irq_q));

  sadc_far_model i_sadc_far_model (.sys_clk(sys_clk), .tmr_req(tmr_req), .pin_req(pin_req),
    .code_req(code_req), .core_q(core_q), .tmr(tmr), .external_start_pin(ext_pin), .core_code(core_code));

  // Counts conversion ticks, the spacing of the last two and the cycles spent tracking.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (core_q.sar_tick) begin
      n_tick <= n_tick + 1;
      gap <= cyc - last_tick;
      last_tick <= cyc;
    end
    if (core_q.track) n_track <= n_track + 1;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Compares a seen value with the expected one and counts the outcome.
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Ends the run when a wait has used up its bound.
  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      failures++;
      print_verdict();
    end
  endtask

  // One register write; address and data are released as each is taken.
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 50);
    last_resp = bresp;
    bready <= 1'b0;
    bound(n, 50);
    // One more edge so registered outputs show the write before the caller looks at them.
    @(posedge sys_clk);
  endtask

  // One register read; the answer lands in rd.
  task automatic rdreg(input logic [11:0] a);
    int n;
    n = 0;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 50);
    rd = rdata;
    last_resp = rresp;
    rready <= 1'b0;
    bound(n, 50);
  endtask

  // Polls the done flag, which is the safe completion signal.
  task automatic wait_done;
    int n;
    n = 0;
    do begin
      rdreg(A_CTRL);
      n++;
    end while (rd[5] !== 1'b1 && n < 100);
    bound(n, 100);
  endtask

  // Main sequence.
  initial begin
    int t0;
    logic [7:0] lo;
    logic [11:0] regs [5];
    regs = '{A_NEG, A_POS, A_CFG, A_IEN, A_CTRL};
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    foreach (regs[k]) begin
      rdreg(regs[k]);
      chk("reset value", rd, 32'h0000_0000);
    end
    chk("idle disabled", {irq_q, core_q.track, core_q.convert}, 32'h0000_0000);
    rdreg(12'h404);
    chk("unmapped read", {last_resp, rd[7:0]}, {`SADC_RESP_SLVERR, 8'h00});
    wr(12'h404, 8'hFF);
    chk("unmapped write", last_resp, `SADC_RESP_SLVERR);
    wr(A_POS, 8'hFF);
    rdreg(A_POS);
    chk("pos supply", {rd, core_q.sel_reserved}, {32'h0000_001F, 1'b0});
    wr(A_POS, 8'h15);
    chk("pos reserved", {core_q.pos_sel, core_q.sel_reserved}, {5'h15, 1'b1});
    wr(A_POS, 8'h14);
    chk("pos last pin", {core_q.pos_sel, core_q.sel_reserved}, {5'h14, 1'b0});
    wr(A_POS, 8'h1E);
    chk("pos temp", {core_q.pos_sel, core_q.sel_reserved}, {5'h1E, 1'b0});
    wstrb <= 4'h0;
    wr(A_POS, 8'h03);
    wstrb <= 4'hF;
    chk("strobe off", core_q.pos_sel, 5'h1E);
    wr(A_IEN, 8'h01);
    wr(A_CTRL, 8'h80);
    for (int i = 0; i < 9; i++) begin
      repeat (125) @(posedge sys_clk);
      code_req <= rows[i][25:16];
      wr(A_NEG, {3'b000, rows[i][31:27]});
      wr(A_CFG, {5'(i + 4), rows[i][26], 2'b00});
      chk("mode", {core_q.single_ended, core_q.neg_sel}, {rows[i][31:27] == 5'h1F, rows[i][31:27]});
      t0 = n_tick;
      wr(A_CTRL, 8'h90);
      rdreg(A_CTRL);
      chk("busy", {rd, core_q.track}, {32'h0000_0090, 1'b0});
      wait_done();
      chk("done", {rd, irq_q, core_q.track}, {32'h0000_00A0, 2'b11});
      chk("ticks", n_tick - t0, CC);
      chk("tick gap", gap, i + 5);
      rdreg(A_RESL);
      lo = rd[7:0];
      rdreg(A_RESH);
      chk("result", {rd[7:0], lo}, rows[i][15:0]);
    end
    wr(A_CFG, 8'h00);
    for (int i = 0; i < 17; i++) begin
      wr(A_CTRL, trg[i][18:11]);
      tmr_req <= trg[i][10:3];
      pin_req <= trg[i][2];
      standby <= trg[i][1];
      @(posedge sys_clk);
      tmr_req <= 8'h00;
      repeat (125) @(posedge sys_clk);
      pin_req <= 1'b0;
      standby <= 1'b0;
      rdreg(A_CTRL);
      chk("started", rd[5], trg[i][0]);
    end
    wr(A_CFG, 8'h08);
    wr(A_CTRL, 8'hC0);
    t0 = n_track;
    wr(A_CTRL, 8'hD0);
    wait_done();
    chk("track span", n_track - t0, 6);
    wr(A_CTRL, 8'hC4);
    repeat (10) @(posedge sys_clk);
    chk("track pin low", core_q.track, 1'b1);
    pin_req <= 1'b1;
    wait_done();
    chk("pin start", {rd, core_q.track}, {32'h0000_00E4, 1'b0});
    pin_req <= 1'b0;
    wr(A_IEN, 8'h00);
    repeat (125) @(posedge sys_clk);
    wr(A_CTRL, 8'h90);
    wait_done();
    chk("irq masked", irq_q, 1'b0);
    wr(A_IEN, 8'h01);
    repeat (2) @(posedge sys_clk);
    chk("irq unmasked", irq_q, 1'b1);
    wr(A_CTRL, 8'h80);
    repeat (2) @(posedge sys_clk);
    chk("irq cleared", irq_q, 1'b0);
    // A reset in mid-conversion returns every register and output to idle.
    wr(A_CTRL, 8'h90);
    rst_b <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    rdreg(A_CTRL);
    chk("mid reset", {rd[7:0], irq_q, core_q}, 32'h0000_0000);
    print_verdict();
  end
endmodule
